// file: rtl/gcm_pkg.sv
// How it works
// RULE1 - output is input times build-time gain
// RULE2 - gain is one scalar constant
// RULE3 - gain masked to its chosen format
// RULE4 - gain integer bits include sign bit
// RULE5 - gain fraction bits only when signed fractional
// RULE6 - zero or more pipeline stages delay result
// RULE7 - phase, enable, clear need one stage
// RULE8 - repeating phase pattern gates captures
// RULE9 - pattern 1 captures every clock
// RULE10 - pattern 10 captures every other clock
// RULE11 - pattern 0100 captures second of four
// RULE12 - optional clock enable qualifies pipeline updates
// RULE13 - optional asynchronous clear empties pipeline
// RULE14 - result width li+lk+2*max fraction
// RULE15 - msb is two's complement sign
// RULE16 - no capture holds, clear forces zero
package gcm_pkg;

  // number format of the gain constant
  typedef enum logic [1:0] {
    GCM_SIGNED_INT,
    GCM_SIGNED_FRAC,
    GCM_UNSIGNED_INT
  } gcm_fmt_t;

  // register bus geometry
  localparam int          GCM_ADDR_W     = 8;
  localparam int          GCM_DATA_W     = 32;
  localparam int          GCM_STRB_W     = 4;
  // register byte offsets
  localparam logic [7:0]  GCM_OFF_CTRL   = 8'h00;
  localparam logic [7:0]  GCM_OFF_STATUS = 8'h04;
  localparam logic [7:0]  GCM_OFF_GAIN   = 8'h08;
  localparam logic [7:0]  GCM_OFF_RESULT = 8'h0c;
  // control fields
  localparam int          GCM_CTRL_EN    = 0;
  localparam int          GCM_CTRL_PCLR  = 1;
  localparam logic        GCM_EN_RST     = 1'b1;
  // status fields
  localparam int          GCM_ST_PH_LSB  = 0;
  localparam int          GCM_ST_CNT_LSB = 16;
  localparam int          GCM_CNT_W      = 16;
  localparam int          GCM_RUN_W      = 8;
  // response codes
  localparam logic [1:0]  GCM_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  GCM_RESP_SLV   = 2'h2;

  // larger of two widths
  function automatic int gcm_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // fraction bits count only for signed fractional
  function automatic int gcm_frac_eff(input gcm_fmt_t f, input int bits);
    return (f == GCM_SIGNED_FRAC) ? bits : 0;
  endfunction

  // result width from both operand formats
  function automatic int gcm_res_w(input int li, input int ri,
                                   input int lk, input int rk);
    return li + lk + 2 * gcm_max(ri, rk);
  endfunction

endpackage

// file: rtl/gcm_pipe.sv
`timescale 1ns/10ps
// shift chain of result stages, async clearable
module gcm_pipe #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_aclr,
  input  wire logic             i_cap,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  // all stages in one word
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stg;
  } gcm_pipe_st_t;

  gcm_pipe_st_t st_r;    // registered stages
  gcm_pipe_st_t st_nxt;  // next stages

  // shift on capture, hold otherwise
  always_comb begin
    st_nxt = st_r;
    if (i_sys_rst) begin
      st_nxt = '0;
    end else if (i_cap) begin
      st_nxt.stg[0] = i_d;
      for (int i = 1; i < DEPTH; i++) begin
        st_nxt.stg[i] = st_r.stg[i-1];
      end
    end
  end

  // clear wins over the clock
  always_ff @(posedge i_clk or posedge i_aclr) begin
    if (i_aclr) begin
      st_r <= '0; // RULE13
    end else begin
      st_r <= st_nxt; // RULE16
    end
  end

  assign o_q = st_r.stg[DEPTH-1];

endmodule

// file: rtl/gcm_axil.sv
`timescale 1ns/10ps
// axi4-lite slave front end, one access each way
module gcm_axil (
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic                          i_awvalid,
  output logic                               o_awready,
  input  wire logic [gcm_pkg::GCM_ADDR_W-1:0] i_awaddr,
  input  wire logic                          i_wvalid,
  output logic                               o_wready,
  input  wire logic [gcm_pkg::GCM_DATA_W-1:0] i_wdata,
  input  wire logic [gcm_pkg::GCM_STRB_W-1:0] i_wstrb,
  output logic                               o_bvalid,
  input  wire logic                          i_bready,
  output logic [1:0]                         o_bresp,
  input  wire logic                          i_arvalid,
  output logic                               o_arready,
  input  wire logic [gcm_pkg::GCM_ADDR_W-1:0] i_araddr,
  output logic                               o_rvalid,
  input  wire logic                          i_rready,
  output logic [gcm_pkg::GCM_DATA_W-1:0]     o_rdata,
  output logic [1:0]                         o_rresp,
  output logic                               o_wr_stb,
  output logic [gcm_pkg::GCM_ADDR_W-1:0]     o_wr_addr,
  output logic [gcm_pkg::GCM_DATA_W-1:0]     o_wr_data,
  output logic [gcm_pkg::GCM_STRB_W-1:0]     o_wr_strb,
  input  wire logic                          i_wr_err,
  output logic [gcm_pkg::GCM_ADDR_W-1:0]     o_rd_addr,
  input  wire logic [gcm_pkg::GCM_DATA_W-1:0] i_rd_data,
  input  wire logic                          i_rd_err
);

  // whole slave state
  typedef struct packed {
    logic                          awready;
    logic                          wready;
    logic                          aw_got;
    logic                          w_got;
    logic [gcm_pkg::GCM_ADDR_W-1:0] waddr;
    logic [gcm_pkg::GCM_DATA_W-1:0] wdata;
    logic [gcm_pkg::GCM_STRB_W-1:0] wstrb;
    logic                          wr_stb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rd_pend;
    logic [gcm_pkg::GCM_ADDR_W-1:0] raddr;
    logic                          rvalid;
    logic [gcm_pkg::GCM_DATA_W-1:0] rdata;
    logic [1:0]                    rresp;
  } gcm_axil_st_t;

  gcm_axil_st_t s_r;    // registered state
  gcm_axil_st_t s_nxt;  // next state

  // handshakes, write commit, read return
  always_comb begin
    s_nxt        = s_r;
    s_nxt.wr_stb = 1'b0;
    if (i_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr  = i_awaddr;
    end
    if (i_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = i_wdata;
      s_nxt.wstrb = i_wstrb;
    end
    // both halves held: commit and answer
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.wr_stb = 1'b1;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = i_wr_err ? gcm_pkg::GCM_RESP_SLV : gcm_pkg::GCM_RESP_OKAY;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
    end else if (s_r.bvalid && i_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (i_arvalid && s_r.arready) begin
      s_nxt.rd_pend = 1'b1;
      s_nxt.raddr   = i_araddr;
    end
    // read data sampled one cycle after address
    if (s_r.rd_pend) begin
      s_nxt.rd_pend = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rdata   = i_rd_data;
      s_nxt.rresp   = i_rd_err ? gcm_pkg::GCM_RESP_SLV : gcm_pkg::GCM_RESP_OKAY;
    end else if (s_r.rvalid && i_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid && !s_nxt.wr_stb;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid && !s_nxt.wr_stb;
    s_nxt.arready = !s_nxt.rd_pend && !s_nxt.rvalid;
    if (i_sys_rst) begin
      s_nxt = '0;
    end
  end

  // single state register
  always_ff @(posedge i_clk) begin
    s_r <= s_nxt;
  end

  assign o_awready = s_r.awready;
  assign o_wready  = s_r.wready;
  assign o_bvalid  = s_r.bvalid;
  assign o_bresp   = s_r.bresp;
  assign o_arready = s_r.arready;
  assign o_rvalid  = s_r.rvalid;
  assign o_rdata   = s_r.rdata;
  assign o_rresp   = s_r.rresp;
  assign o_wr_stb  = s_r.wr_stb;
  assign o_wr_addr = s_r.waddr;
  assign o_wr_data = s_r.wdata;
  assign o_wr_strb = s_r.wstrb;
  assign o_rd_addr = s_r.raddr;

  a_bresp_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_bvalid && !i_bready) |=> (o_bvalid && $stable(o_bresp)))
    else $error("write response dropped before taken");

  a_rdata_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_rvalid && !i_rready) |=> (o_rvalid && $stable(o_rdata)))
    else $error("read data changed before taken");

endmodule

// file: rtl/gcm_top.sv
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// constant gain multiplier with phase-gated pipeline
module gcm_top #(
  parameter int                IN_INT_BITS    = 8,
  parameter int                IN_FRAC_BITS   = 8,
  parameter gcm_pkg::gcm_fmt_t GAIN_FMT       = gcm_pkg::GCM_SIGNED_FRAC,
  parameter int                GAIN_INT_BITS  = 2,
  parameter int                GAIN_FRAC_BITS = 8,
  parameter longint            GAIN_VALUE     = 64'sd384,
  parameter int                PIPE_STAGES    = 2,
  parameter int                PHASE_LEN      = 1,
  parameter logic [PHASE_LEN-1:0] PHASE_PAT   = 1'b1,
  parameter bit                USE_ENA        = 1'b1,
  parameter bit                USE_ACLR       = 1'b1,
  localparam int IN_W  = IN_INT_BITS + IN_FRAC_BITS,
  localparam int GK_FR = gcm_pkg::gcm_frac_eff(GAIN_FMT, GAIN_FRAC_BITS),
  localparam int RES_W = gcm_pkg::gcm_res_w(IN_INT_BITS, IN_FRAC_BITS,
                                            GAIN_INT_BITS, GK_FR)
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic [IN_W-1:0]               i_din,
  input  wire logic                          i_ena,
  input  wire logic                          i_aclr,
  output logic      [RES_W-1:0]              o_result,
  input  wire logic                          i_awvalid,
  output logic                               o_awready,
  input  wire logic [gcm_pkg::GCM_ADDR_W-1:0] i_awaddr,
  input  wire logic                          i_wvalid,
  output logic                               o_wready,
  input  wire logic [gcm_pkg::GCM_DATA_W-1:0] i_wdata,
  input  wire logic [gcm_pkg::GCM_STRB_W-1:0] i_wstrb,
  output logic                               o_bvalid,
  input  wire logic                          i_bready,
  output logic [1:0]                         o_bresp,
  input  wire logic                          i_arvalid,
  output logic                               o_arready,
  input  wire logic [gcm_pkg::GCM_ADDR_W-1:0] i_araddr,
  output logic                               o_rvalid,
  input  wire logic                          i_rready,
  output logic [gcm_pkg::GCM_DATA_W-1:0]     o_rdata,
  output logic [1:0]                         o_rresp
);

  // gain word: integer part carries the sign bit
  localparam int GK_W     = GAIN_INT_BITS + GK_FR; // RULE4 RULE5
  // binary point alignment into the result
  localparam int MAX_FR   = gcm_pkg::gcm_max(IN_FRAC_BITS, GK_FR);
  localparam int SHIFT    = 2 * MAX_FR - IN_FRAC_BITS - GK_FR; // RULE14
  localparam int PRD_W    = IN_W + GK_W + 1;
  // one scalar constant, cut to its format width
  localparam logic [GK_W-1:0] GAIN_K = GK_W'(GAIN_VALUE); // RULE2 RULE3
  localparam bit  GAIN_SGN = (GAIN_FMT != gcm_pkg::GCM_UNSIGNED_INT);
  // unsigned gain gets a zero above its msb
  localparam logic signed [GK_W:0] GAIN_EXT =
    GAIN_SGN ? {GAIN_K[GK_W-1], GAIN_K} : {1'b0, GAIN_K}; // RULE15
  localparam bit  GAIN_POS = (GAIN_EXT > 0);
  // phase counter geometry
  localparam int  PH_W    = (PHASE_LEN > 1) ? $clog2(PHASE_LEN) : 1;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(PHASE_LEN - 1);
  // readable slices of result and gain
  localparam int  RD_RW   = (RES_W < gcm_pkg::GCM_DATA_W) ? RES_W
                                                         : gcm_pkg::GCM_DATA_W;
  localparam int  RD_GW   = (GK_W < gcm_pkg::GCM_DATA_W) ? GK_W
                                                        : gcm_pkg::GCM_DATA_W;
  // saturation point of the capture run counter
  localparam logic [gcm_pkg::GCM_RUN_W-1:0] RUN_MAX = '1;

  // all block state in one word
  typedef struct packed {
    logic [PH_W-1:0]                 phase;    // current clock phase
    logic                            soft_en;  // software run enable
    logic [gcm_pkg::GCM_CNT_W-1:0]   cap_cnt;  // samples captured
    logic [gcm_pkg::GCM_RUN_W-1:0]   en_run;   // consecutive captures
  } gcm_top_st_t;

  gcm_top_st_t st_r;    // registered state
  gcm_top_st_t st_nxt;  // next state

  logic signed [PRD_W-1:0]         prod_w;   // raw product
  logic        [RES_W-1:0]         res_comb; // aligned product
  logic                            ph_sel;   // pattern bit of this phase
  logic                            ena_ok;   // enable pin, if used
  logic                            aclr_eff; // clear pin, if used
  logic                            cap_en;   // pipeline capture strobe
  logic                            ph_clr;   // software phase restart
  logic                            wr_stb;   // register write pulse
  logic [gcm_pkg::GCM_ADDR_W-1:0]  wr_addr;  // register write address
  logic [gcm_pkg::GCM_DATA_W-1:0]  wr_data;  // register write data
  logic [gcm_pkg::GCM_STRB_W-1:0]  wr_strb;  // register write lanes
  logic [gcm_pkg::GCM_ADDR_W-1:0]  rd_addr;  // register read address
  logic [gcm_pkg::GCM_DATA_W-1:0]  rd_data;  // register read data
  logic                            wr_err;   // unmapped write
  logic                            rd_err;   // unmapped read

  // true for the four mapped words
  function automatic logic reg_hit(input logic [gcm_pkg::GCM_ADDR_W-1:0] a);
    return (a == gcm_pkg::GCM_OFF_CTRL)   || (a == gcm_pkg::GCM_OFF_STATUS) ||
           (a == gcm_pkg::GCM_OFF_GAIN)   || (a == gcm_pkg::GCM_OFF_RESULT);
  endfunction

  // signed product, both sides sign extended
  assign prod_w   = PRD_W'($signed(i_din)) * PRD_W'(GAIN_EXT); // RULE1 RULE15
  // place binary point at twice the larger fraction
  assign res_comb = RES_W'(prod_w) <<< SHIFT; // RULE14

  // pins only matter once a stage exists
  assign ena_ok   = (USE_ENA && PIPE_STAGES > 0) ? i_ena : 1'b1; // RULE7 RULE12
  assign aclr_eff = (USE_ACLR && PIPE_STAGES > 0) ? i_aclr : 1'b0; // RULE7 RULE13
  // first pattern character is phase zero
  assign ph_sel   = PHASE_PAT[PHASE_LEN - 1 - int'(st_r.phase)]; // RULE8
  assign cap_en   = ph_sel && ena_ok && st_r.soft_en; // RULE9 RULE16

  // write side effects
  assign ph_clr   = wr_stb && (wr_addr == gcm_pkg::GCM_OFF_CTRL) &&
                    wr_strb[0] && wr_data[gcm_pkg::GCM_CTRL_PCLR];
  // unmapped offsets answer with a slave error
  assign wr_err   = !reg_hit(wr_addr);
  assign rd_err   = !reg_hit(rd_addr);

  // register read mux
  always_comb begin
    rd_data = '0;
    case (rd_addr)
      gcm_pkg::GCM_OFF_CTRL: begin
        rd_data[gcm_pkg::GCM_CTRL_EN] = st_r.soft_en;
      end
      gcm_pkg::GCM_OFF_STATUS: begin
        rd_data[gcm_pkg::GCM_ST_PH_LSB +: PH_W] = st_r.phase;
        rd_data[gcm_pkg::GCM_ST_CNT_LSB +: gcm_pkg::GCM_CNT_W] = st_r.cap_cnt;
      end
      gcm_pkg::GCM_OFF_GAIN: begin
        rd_data[RD_GW-1:0] = GAIN_K[RD_GW-1:0];
      end
      gcm_pkg::GCM_OFF_RESULT: begin
        rd_data[RD_RW-1:0] = o_result[RD_RW-1:0];
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  // phase walk, control register, capture counters
  always_comb begin
    st_nxt = st_r;
    // phase advances on every clock and wraps, a ph_clr write restarts it at zero
    if (ph_clr || st_r.phase == PH_LAST) begin
      st_nxt.phase = '0; // RULE8 RULE10 RULE11
    end else begin
      st_nxt.phase = st_r.phase + 1'b1;
    end
    // software run enable in control bit
    if (wr_stb && wr_addr == gcm_pkg::GCM_OFF_CTRL && wr_strb[0]) begin
      st_nxt.soft_en = wr_data[gcm_pkg::GCM_CTRL_EN];
    end
    // count captured samples
    if (cap_en) begin
      st_nxt.cap_cnt = st_r.cap_cnt + 1'b1;
    end
    // run of back to back captures, saturating
    if (!cap_en || aclr_eff) begin
      st_nxt.en_run = '0;
    end else if (st_r.en_run != RUN_MAX) begin
      st_nxt.en_run = st_r.en_run + 1'b1;
    end
    // defined control state after reset
    if (i_sys_rst) begin
      st_nxt         = '0;
      st_nxt.soft_en = gcm_pkg::GCM_EN_RST;
    end
  end

  // single state register
  always_ff @(posedge i_clk) begin
    st_r <= st_nxt;
  end

  // stage chain or straight product
  generate
    if (PIPE_STAGES > 0) begin : g_pipe
      gcm_pipe #(
        .WIDTH (RES_W),
        .DEPTH (PIPE_STAGES)
      ) u_pipe (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_aclr    (aclr_eff),
        .i_cap     (cap_en),
        .i_d       (res_comb),
        .o_q       (o_result)
      ); // RULE6 RULE16
    end else begin : g_comb
      // zero stages: purely combinational
      assign o_result = res_comb; // RULE6
    end
  endgenerate

  // register bus slave
  // writes commit one cycle after both halves arrive
  gcm_axil u_axil (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_awaddr  (i_awaddr),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .o_bresp   (o_bresp),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .i_araddr  (i_araddr),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_wr_stb  (wr_stb),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_err  (wr_err),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err)
  );

  // phase restarts after the last one
  a_phase_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE8
    (st_r.phase == PH_LAST) |=> (st_r.phase == '0))
    else $error("phase did not wrap");

  // reset returns phase to zero
  a_reset_phase: assert property (@(posedge i_clk)
    i_sys_rst |=> (st_r.phase == '0 && st_r.soft_en == gcm_pkg::GCM_EN_RST))
    else $error("reset left phase or enable wrong");

  // negative sample, positive gain: sign bit set
  a_sign_out: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE15
    ($signed(i_din) < 0 && GAIN_POS) |-> res_comb[RES_W-1])
    else $error("product sign bit wrong");

  // capture counter steps by one per capture
  a_cnt_step: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE8
    cap_en |=> (st_r.cap_cnt == $past(st_r.cap_cnt) + 1'b1))
    else $error("capture count did not step");

  // run enable low blocks every capture
  a_run_block: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE16
    !st_r.soft_en |-> !cap_en)
    else $error("capture while run enable low");

  // checks that need a stage, then per-pattern checks
  generate
    if (PIPE_STAGES > 0) begin : g_chk
      // no capture: output holds
      a_hold_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE16
        (!cap_en && !aclr_eff) |=> ($stable(o_result) || aclr_eff))
        else $error("output moved without capture");

      // enable low freezes the pipeline
      a_ena_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE12
        (USE_ENA && !i_ena && !aclr_eff) |=> ($stable(o_result) || aclr_eff))
        else $error("enable low did not hold output");

      // clear empties the pipeline
      a_aclr_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE13
        aclr_eff |-> (o_result == '0))
        else $error("clear did not zero output");

      // steady captures give the product stages later
      a_pipe_delay: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE6
        (st_r.en_run >= PIPE_STAGES && !aclr_eff) |->
          (o_result == $past(res_comb, PIPE_STAGES)))
        else $error("result latency wrong");
    end
    if (PHASE_LEN == 1 && PHASE_PAT == 1'b1) begin : g_chk1
      // single one: capture every clock
      a_every_clk: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE9
        (st_r.soft_en && ena_ok)[*2] |-> cap_en)
        else $error("missed a capture under pattern 1");
    end
    if (PHASE_LEN == 2 && PHASE_PAT == 2'b10) begin : g_chk2
      // alternate clocks only
      a_alt_phase: assert property (@(posedge i_clk) // RULE10
        disable iff (i_sys_rst || ph_clr)
        cap_en |=> !cap_en)
        else $error("pattern 10 captured twice in a row");
    end
    if (PHASE_LEN == 4 && PHASE_PAT == 4'b0100) begin : g_chk4
      // second of four, three blocked after
      a_quad_gap: assert property (@(posedge i_clk) // RULE11
        disable iff (i_sys_rst || ph_clr)
        cap_en |-> (st_r.phase == PH_W'(1)) ##1 (!cap_en)[*3])
        else $error("pattern 0100 captured in wrong phase");
    end
  endgenerate

endmodule

// file: bench/gcm_src.sv
`timescale 1ns/10ps
// upstream datapath stage feeding samples to the multiplier
module gcm_src (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [15:0] i_d,
  output logic      [15:0] o_din
);
  // one register stage, cleared by reset
  always_ff @(posedge i_clk) begin
    o_din <= i_sys_rst ? 16'h0000 : i_d;
  end
endmodule

// file: bench/tb.sv
`timescale 1ns/10ps
// self-checking bench for the constant gain multiplier
module tb;
  logic        i_clk, i_sys_rst, i_ena, i_aclr;       // clock, reset, pipe controls
  logic [15:0] src_d, din;                            // source input, sample to design
  logic [25:0] o_result;                              // product
  logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
  logic        i_arvalid, o_arready, o_rvalid, i_rready;
  logic [7:0]  i_awaddr, i_araddr;                    // bus addresses
  logic [31:0] i_wdata, o_rdata, rd;                  // bus data, last read
  logic [3:0]  i_wstrb;                               // byte lanes
  logic [1:0]  o_bresp, o_rresp, rs;                  // responses, last bus response
  logic [25:0] prev, q_result, qprev;                 // previous product, quad copy result
  int          bad_count, tests_run, nchg;            // mismatch, compare, quad change counts
  // samples beside products for a gain of 1.5
  logic [15:0] rin [0:4] = '{16'h0100, 16'hff00, 16'h7fff, 16'h8000, 16'h0001};
  logic [25:0] rexp [0:4] = '{26'h0018000, 26'h3fe8000, 26'h0bffe80, 26'h3400000, 26'h0000180};

  gcm_src gcm_src_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_d(src_d), .o_din(din));
  gcm_top gcm_top_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_din(din), .i_ena(i_ena),
    .i_aclr(i_aclr), .o_result(o_result), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp));

  // quad-phase copy with an oversized gain, sharing the bus inputs
  if (1) begin : g_quad
    gcm_top #(.GAIN_VALUE(64'sh580), .PHASE_LEN(4), .PHASE_PAT(4'h4)) gcm_top_inst (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_din(din), .i_ena(i_ena), .i_aclr(i_aclr),
      .o_result(q_result), .i_awvalid(i_awvalid), .o_awready(), .i_awaddr(i_awaddr),
      .i_wvalid(i_wvalid), .o_wready(), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
      .o_bvalid(), .i_bready(i_bready), .o_bresp(), .i_arvalid(i_arvalid),
      .o_arready(), .i_araddr(i_araddr), .o_rvalid(), .i_rready(i_rready),
      .o_rdata(), .o_rresp());
  end

  // 100 mhz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus write, address and data offered together
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_awaddr  <= a;
    i_wvalid  <= 1'b1;
    i_wdata   <= d;
    i_wstrb   <= 4'hf;
    i_bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    rs = o_bresp;
    i_bready <= 1'b0;
  endtask

  // bus read, data and response kept in rd and rs
  task axr(input logic [7:0] a);
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr  <= a;
    i_rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    rd = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
  endtask

  // wait n edges then look once outputs settle
  task settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // counts, verdict, end of run
  task give_verdict();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end

  // main sequence
  initial begin
    {i_ena, i_aclr, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 7'h40;
    {i_awaddr, i_araddr, i_wdata, i_wstrb, src_d} = '0;
    {bad_count, tests_run, nchg} = '0;
    i_sys_rst = 1'b1;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    settle(2);
    chk(32'(o_result), 32'h0);
    axr(gcm_pkg::GCM_OFF_GAIN);
    chk(rd, 32'h180);
    axw(gcm_pkg::GCM_OFF_GAIN, 32'h0);
    chk(32'(rs), 32'(gcm_pkg::GCM_RESP_OKAY));
    axr(gcm_pkg::GCM_OFF_GAIN);
    chk(rd, 32'h180);
    axr(8'h40);
    chk(32'(rs), 32'(gcm_pkg::GCM_RESP_SLV));
    chk(rd, 32'h0);
    axw(8'h40, 32'h0);
    chk(32'(rs), 32'(gcm_pkg::GCM_RESP_SLV));
    // table rows: old product two edges on, new one a third edge on
    prev = '0;
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clk);
      src_d <= rin[i];
      settle(2);
      chk(32'(o_result), 32'(prev));
      settle(1);
      chk(32'(o_result), 32'(rexp[i]));
      prev = rexp[i];
    end
    // clock enable low holds the pipe
    @(posedge i_clk);
    i_ena <= 1'b0;
    src_d <= 16'h0100;
    settle(4);
    chk(32'(o_result), 32'h180);
    @(posedge i_clk);
    i_ena <= 1'b1;
    settle(3);
    chk(32'(o_result), 32'h18000);
    // run enable cleared blocks every capture
    axw(gcm_pkg::GCM_OFF_CTRL, 32'h0);
    src_d <= 16'hff00;
    settle(4);
    chk(32'(o_result), 32'h18000);
    axw(gcm_pkg::GCM_OFF_CTRL, 32'h1);
    settle(4);
    chk(32'(o_result), 32'h3fe8000);
    // async clear empties the pipe without a clock edge
    @(posedge i_clk);
    i_aclr <= 1'b1;
    #2;
    chk(32'(o_result), 32'h0);
    settle(2);
    chk(32'(o_result), 32'h0);
    @(posedge i_clk);
    i_aclr <= 1'b0;
    settle(3);
    chk(32'(o_result), 32'h3fe8000);
    // quad copy: oversized gain masked to 1.5, one capture in four
    @(posedge i_clk);
    src_d <= 16'h0100;
    settle(12);
    chk(32'(q_result), 32'h18000);
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clk);
      src_d <= 16'(k + 2);
      #1;
      if (k >= 8 && q_result !== qprev) nchg++;
      qprev = q_result;
    end
    chk(nchg, 32'h2);
    // mid-run reset: run enable back to one, pipe empty
    axw(gcm_pkg::GCM_OFF_CTRL, 32'h0);
    i_sys_rst <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    settle(2);
    chk(32'(o_result), 32'h0);
    axr(gcm_pkg::GCM_OFF_CTRL);
    chk(rd, 32'h1);
    give_verdict();
  end
endmodule
